// ---- cbr_defines.svh ----
// constants of the card bridge control block: offsets, fields, resets
// assumes byte offsets of a function's configuration space
`ifndef CBR_DEFINES_SVH
`define CBR_DEFINES_SVH

// ==========================================
// configuration offsets
`define CBR_CFG_DW_OFF 8'h3C
`define CBR_PIN_CODE_OFF 8'h3D
`define CBR_BCTL_OFF 8'h3E

// ==========================================
// bridge control fields
`define CBR_BCTL_RST 16'h0340
`define CBR_BCTL_RW_MASK 16'h07EF
`define CBR_B_POST 10
`define CBR_B_PF1 9
`define CBR_B_PF0 8
`define CBR_B_IRQSEL 7
`define CBR_B_CARD_RST 6
`define CBR_B_MABT 5
`define CBR_B_VGA 3
`define CBR_B_ISA 2
`define CBR_B_SERR 1
`define CBR_B_PERR 0

// ==========================================
// interrupt pin codes
`define CBR_PIN_INTA 8'h01
`define CBR_PIN_INTB 8'h02
`define CBR_PIN_INTC 8'h03

// ==========================================
// forwarding decode
`define CBR_ISA_TOP 32'h0000FFFF
`define CBR_VGA_MEM_LO 32'h000A0000
`define CBR_VGA_MEM_HI 32'h000BFFFF
`define CBR_VGA_IO1_LO 16'h03B0
`define CBR_VGA_IO1_HI 16'h03BB
`define CBR_VGA_IO2_LO 16'h03C0
`define CBR_VGA_IO2_HI 16'h03DF

`endif

// ---- cbr_pkg.sv ----
// types of the card bridge control block
// assumes cbr_defines.svh for all numeric constants
`default_nettype none

package cbr_pkg;

	// per-socket bridge control bits
	typedef struct packed {
		logic post_en;
		logic win1_prefetchable;
		logic win0_prefetchable;
		logic irq_legacy;
		logic card_rst;
		logic vga_forward_en;
		logic isa_alias_en;
		logic card_syserr_fwd_en;
		logic card_parity_resp_en;
	} cbr_sock_cfg_t;

	// configuration access request
	typedef struct packed {
		logic req;
		logic we;
		logic [1:0] func;
		logic [7:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} cbr_cfg_req_t;

	// forwarding decision request
	typedef struct packed {
		logic valid;
		logic is_io;
		logic sock;
		logic [31:0] addr;
	} cbr_fwd_req_t;

	typedef enum logic [1:0] {
		CBR_F_SOCK0 = 2'b00,
		CBR_F_SOCK1 = 2'b01,
		CBR_F_OHCI = 2'b10,
		CBR_F_NONE = 2'b11
	} cbr_func_t;

	typedef enum logic {
		CBR_IDLE = 1'b0,
		CBR_RESP = 1'b1
	} cbr_cfg_state_t;

endpackage : cbr_pkg

`default_nettype wire

// ---- cbr_sync3.sv ----
// three-flop pin synchroniser with agreement filter
// assumes inputs asynchronous to sys_clk_i
`timescale 1ns/1ps
`default_nettype none

module cbr_sync3 #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] agree;

	assign agree = ~(s2_q ^ s3_q);

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			s1_q <= INIT;
			s2_q <= INIT;
			s3_q <= INIT;
			q_o <= INIT;
		end
		else
		begin
			s1_q <= d_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			q_o <= (agree & s3_q) | (~agree & q_o);
		end
	end

endmodule : cbr_sync3

`default_nettype wire

// ---- cbr_sock_regs.sv ----
// per-socket bridge control bits of one card function
// assumes host_rst_i is already synchronised to sys_clk_i
`timescale 1ns/1ps
`default_nettype none
`include "cbr_defines.svh"

module cbr_sock_regs (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic host_rst_i,
	input wire logic pme_en_i,
	input wire logic wr_lo_i,
	input wire logic wr_hi_i,
	input wire logic [15:0] wdata_i,
	output cbr_pkg::cbr_sock_cfg_t cfg_o
);

	localparam logic [15:0] RST = `CBR_BCTL_RST;

	cbr_pkg::cbr_sock_cfg_t rst_val;
	cbr_pkg::cbr_sock_cfg_t cfg_d;
	logic rst_bit_keep;

	assign rst_val = '{
		post_en: RST[`CBR_B_POST],
		win1_prefetchable: RST[`CBR_B_PF1],
		win0_prefetchable: RST[`CBR_B_PF0],
		irq_legacy: RST[`CBR_B_IRQSEL],
		card_rst: RST[`CBR_B_CARD_RST],
		vga_forward_en: RST[`CBR_B_VGA],
		isa_alias_en: RST[`CBR_B_ISA],
		card_syserr_fwd_en: RST[`CBR_B_SERR],
		card_parity_resp_en: RST[`CBR_B_PERR]
	};

	// writes touch only writable bits; host reset spares card reset with pme
	assign rst_bit_keep = pme_en_i; // RQ10
	assign cfg_d = '{
		post_en: wr_hi_i ? wdata_i[`CBR_B_POST] : cfg_o.post_en, // RQ5
		win1_prefetchable: wr_hi_i ? wdata_i[`CBR_B_PF1]
			: cfg_o.win1_prefetchable, // RQ6
		win0_prefetchable: wr_hi_i ? wdata_i[`CBR_B_PF0]
			: cfg_o.win0_prefetchable, // RQ6
		irq_legacy: wr_lo_i ? wdata_i[`CBR_B_IRQSEL] : cfg_o.irq_legacy,
		card_rst: wr_lo_i ? wdata_i[`CBR_B_CARD_RST]
			: cfg_o.card_rst, // RQ8
		vga_forward_en: wr_lo_i ? wdata_i[`CBR_B_VGA]
			: cfg_o.vga_forward_en,
		isa_alias_en: wr_lo_i ? wdata_i[`CBR_B_ISA] : cfg_o.isa_alias_en,
		card_syserr_fwd_en: wr_lo_i ? wdata_i[`CBR_B_SERR]
			: cfg_o.card_syserr_fwd_en, // RQ14
		card_parity_resp_en: wr_lo_i ? wdata_i[`CBR_B_PERR]
			: cfg_o.card_parity_resp_en // RQ15
	};

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			cfg_o <= rst_val;
		else if (host_rst_i)
		begin
			cfg_o <= rst_val;
			if (rst_bit_keep)
				cfg_o.card_rst <= cfg_o.card_rst; // RQ10
		end
		else
			cfg_o <= cfg_d;
	end

endmodule : cbr_sock_regs

`default_nettype wire

// ---- cbr_top.sv ----
// card bridge control: interrupt pin codes and bridge control registers
// assumes configuration cycles arrive decoded as one-cycle requests
// How it works
// RQ1: pin code per function: A, B, C with both tie bits clear.
// RQ2: A-B tie alone joins A and B; functions 0,1 report A, 2 reports C.
// RQ3: all-tie joins A, B, C; every function reports A.
// RQ4: control bits 15-11 and 4 read zero; register resets to 0340h.
// RQ5: bit 10 enables burst write posting, held per socket.
// RQ6: bits 9 and 8 mark windows 1 and 0 prefetchable, default set.
// RQ7: bit 7 routes card interrupts to PCI lines or legacy IRQ.
// RQ8: bit 6 drives card reset; resets to 1.
// RQ9: host reset input also asserts card reset, whatever bit 6 holds.
// RQ10: with pme, only global reset sets bit 6; else either reset.
// RQ11: bit 5, shared, reports card master aborts as target abort, SERR.
// RQ12: bit 3 forwards VGA addresses across the bridge.
// RQ13: bit 2 blocks I/O to upper 768 bytes of each 1K under 64K.
// RQ14: bit 1 forwards card system error to PCI SERR.
// RQ15: bit 0 reports card parity errors on the parity error pin.
// RQ16: software should touch global bits only through function 0; the block takes bit 5 writes from function 1 too.
// RQ17: writes to read-only and reserved bits change nothing.
`timescale 1ns/1ps
`default_nettype none
`include "cbr_defines.svh"

module cbr_top (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire cbr_pkg::cbr_cfg_req_t cfg_i,
	output logic cfg_ack_o,
	output logic [31:0] cfg_rdata_o,
	input wire logic int_ab_tie_i,
	input wire logic int_abc_tie_i,
	input wire logic pme_en_i,
	input wire logic serr_en_i,
	input wire logic host_reset_in_n_i,
	input wire logic [1:0] card_system_error_n_i,
	input wire logic [1:0] card_irq_n_i,
	input wire logic ohci_irq_i,
	input wire logic [1:0] master_abort_i,
	input wire logic [1:0] parity_err_i,
	input wire cbr_pkg::cbr_fwd_req_t fwd_i,
	output logic [1:0] card_reset_out_n_o,
	output logic [1:0] card_parity_error_n_o,
	output logic serr_n_o,
	output logic target_abort_o,
	output logic [2:0] pci_int_n_o,
	output logic [1:0] legacy_irq_o,
	output logic [1:0] write_post_en_o,
	output logic [1:0] win1_prefetchable_o,
	output logic [1:0] win0_prefetchable_o,
	output logic fwd_ack_o,
	output logic fwd_pass_o,
	output logic fwd_vga_o
);

	// ==========================================
	// decode helpers
	function automatic logic isa_alias_hit(input logic [31:0] a);
		isa_alias_hit = (a <= `CBR_ISA_TOP) && (a[9:8] != 2'b00);
	endfunction : isa_alias_hit

	function automatic logic vga_hit(input logic io, input logic [31:0] a);
		logic mem_hit;
		logic io_hit;
		mem_hit = (a >= `CBR_VGA_MEM_LO) && (a <= `CBR_VGA_MEM_HI);
		io_hit = (a[31:16] == 16'h0000)
			&& (((a[15:0] >= `CBR_VGA_IO1_LO)
			&& (a[15:0] <= `CBR_VGA_IO1_HI))
			|| ((a[15:0] >= `CBR_VGA_IO2_LO)
			&& (a[15:0] <= `CBR_VGA_IO2_HI)));
		vga_hit = io ? io_hit : mem_hit;
	endfunction : vga_hit

	function automatic logic [7:0] pin_code(input logic [1:0] f,
		input logic ab, input logic abc);
		pin_code = 8'h00;
		unique case (f)
			2'b00:
				pin_code = `CBR_PIN_INTA; // RQ1
			2'b01:
				pin_code = (ab || abc) ? `CBR_PIN_INTA
					: `CBR_PIN_INTB; // RQ2
			2'b10:
				pin_code = abc ? `CBR_PIN_INTA
					: `CBR_PIN_INTC; // RQ3
			2'b11:
				pin_code = 8'h00;
		endcase
	endfunction : pin_code

	// ==========================================
	// pin synchronisers
	logic [4:0] pin_raw;
	logic [4:0] pin_sync;
	logic host_rst;
	logic [1:0] card_serr;
	logic [1:0] card_irq;

	assign pin_raw = {host_reset_in_n_i, card_system_error_n_i,
		card_irq_n_i};

	cbr_sync3 #(
		.W(5),
		.INIT(5'h1F)
	) u_sync (
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.d_i(pin_raw),
		.q_o(pin_sync)
	);

	assign host_rst = ~pin_sync[4];
	assign card_serr = ~pin_sync[3:2];
	assign card_irq = ~pin_sync[1:0];

	// ==========================================
	// configuration access decode
	cbr_pkg::cbr_cfg_state_t st_q;
	cbr_pkg::cbr_cfg_state_t st_d;
	cbr_pkg::cbr_func_t func;
	logic take;
	logic dw_hit;
	logic sock_fn;
	logic wr_lo;
	logic wr_hi;
	logic [1:0] sock_wr_lo;
	logic [1:0] sock_wr_hi;
	logic [15:0] wdata_hi;

	assign func = cbr_pkg::cbr_func_t'(cfg_i.func);
	assign take = cfg_i.req && (st_q == cbr_pkg::CBR_IDLE);
	assign dw_hit = cfg_i.addr[7:2] == 6'(`CBR_CFG_DW_OFF >> 2);
	assign sock_fn = (func == cbr_pkg::CBR_F_SOCK0)
		|| (func == cbr_pkg::CBR_F_SOCK1);
	assign wdata_hi = cfg_i.wdata[31:16] & `CBR_BCTL_RW_MASK; // RQ17
	// pin code byte has no write path at all
	assign wr_lo = take && cfg_i.we && dw_hit && sock_fn
		&& cfg_i.be[2]; // RQ17
	assign wr_hi = take && cfg_i.we && dw_hit && sock_fn
		&& cfg_i.be[3]; // RQ17
	assign sock_wr_lo = {wr_lo && cfg_i.func[0], wr_lo && !cfg_i.func[0]};
	assign sock_wr_hi = {wr_hi && cfg_i.func[0], wr_hi && !cfg_i.func[0]};

	always_comb
	begin
		st_d = st_q;
		unique case (st_q)
			cbr_pkg::CBR_IDLE:
				if (cfg_i.req)
					st_d = cbr_pkg::CBR_RESP;
			cbr_pkg::CBR_RESP:
				st_d = cbr_pkg::CBR_IDLE;
		endcase
	end

	// ==========================================
	// socket registers
	cbr_pkg::cbr_sock_cfg_t sock_cfg [2];
	logic [15:0] bctl_rd [2];
	logic mabt_q;

	genvar gs;
	generate
		for (gs = 0; gs < 2; gs++)
		begin : g_sock
			cbr_sock_regs u_regs (
				.sys_clk_i(sys_clk_i),
				.srst_i(srst_i),
				.host_rst_i(host_rst),
				.pme_en_i(pme_en_i),
				.wr_lo_i(sock_wr_lo[gs]),
				.wr_hi_i(sock_wr_hi[gs]),
				.wdata_i(wdata_hi),
				.cfg_o(sock_cfg[gs])
			);

			// reserved bits 15-11 and 4 stay zero
			always_comb
			begin
				bctl_rd[gs] = 16'h0000; // RQ4
				bctl_rd[gs][`CBR_B_POST] = sock_cfg[gs].post_en;
				bctl_rd[gs][`CBR_B_PF1] = sock_cfg[gs].win1_prefetchable;
				bctl_rd[gs][`CBR_B_PF0] = sock_cfg[gs].win0_prefetchable;
				bctl_rd[gs][`CBR_B_IRQSEL] = sock_cfg[gs].irq_legacy;
				bctl_rd[gs][`CBR_B_CARD_RST] = sock_cfg[gs].card_rst;
				bctl_rd[gs][`CBR_B_MABT] = mabt_q;
				bctl_rd[gs][`CBR_B_VGA] = sock_cfg[gs].vga_forward_en;
				bctl_rd[gs][`CBR_B_ISA] = sock_cfg[gs].isa_alias_en;
				bctl_rd[gs][`CBR_B_SERR] = sock_cfg[gs].card_syserr_fwd_en;
				bctl_rd[gs][`CBR_B_PERR] = sock_cfg[gs].card_parity_resp_en;
			end
		end
	endgenerate

	// ==========================================
	// read data
	logic [7:0] pin_rd;
	logic [31:0] rdata_d;

	assign pin_rd = pin_code(cfg_i.func, int_ab_tie_i, int_abc_tie_i);

	always_comb
	begin
		rdata_d = 32'h00000000;
		if (dw_hit && !cfg_i.we)
		begin
			rdata_d[15:8] = pin_rd;
			if (sock_fn)
				rdata_d[31:16] = bctl_rd[cfg_i.func[0]];
		end
	end

	// ==========================================
	// interrupt routing
	logic [1:0] to_pci;
	logic [2:0] pci_int_d;

	assign to_pci = {card_irq[1] && !sock_cfg[1].irq_legacy,
		card_irq[0] && !sock_cfg[0].irq_legacy}; // RQ7

	// ties move lines B and C onto A, matching the reported codes
	always_comb
	begin
		pci_int_d = 3'b000;
		pci_int_d[0] = to_pci[0];
		if (int_ab_tie_i || int_abc_tie_i)
			pci_int_d[0] = pci_int_d[0] || to_pci[1]; // RQ2
		else
			pci_int_d[1] = to_pci[1];
		if (int_abc_tie_i)
			pci_int_d[0] = pci_int_d[0] || ohci_irq_i; // RQ3
		else
			pci_int_d[2] = ohci_irq_i;
	end

	// ==========================================
	// error reporting
	logic ma_any;
	logic serr_d;
	logic [1:0] serr_fwd;
	logic [1:0] perr_d;

	assign ma_any = |master_abort_i;
	assign serr_fwd = {card_serr[1] && sock_cfg[1].card_syserr_fwd_en,
		card_serr[0] && sock_cfg[0].card_syserr_fwd_en}; // RQ14
	assign serr_d = serr_en_i
		&& ((ma_any && mabt_q) || (|serr_fwd)); // RQ11
	assign perr_d = {parity_err_i[1] && sock_cfg[1].card_parity_resp_en,
		parity_err_i[0] && sock_cfg[0].card_parity_resp_en}; // RQ15

	// ==========================================
	// forwarding decode
	cbr_pkg::cbr_sock_cfg_t fsel;
	logic fwd_block;
	logic fwd_vga_d;

	assign fsel = sock_cfg[fwd_i.sock];
	assign fwd_block = fwd_i.is_io && fsel.isa_alias_en
		&& isa_alias_hit(fwd_i.addr); // RQ13
	assign fwd_vga_d = fsel.vga_forward_en
		&& vga_hit(fwd_i.is_io, fwd_i.addr); // RQ12

	// ==========================================
	// registers
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i || host_rst)
			mabt_q <= 1'b0;
		else if (wr_lo)
			mabt_q <= cfg_i.wdata[16 + `CBR_B_MABT]; // RQ11
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			st_q <= cbr_pkg::CBR_IDLE;
			cfg_ack_o <= 1'b0;
			cfg_rdata_o <= 32'h00000000;
		end
		else
		begin
			st_q <= st_d;
			cfg_ack_o <= take;
			if (take)
				cfg_rdata_o <= rdata_d;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			card_reset_out_n_o <= 2'b00;
			pci_int_n_o <= 3'b111;
			legacy_irq_o <= 2'b00;
		end
		else
		begin
			card_reset_out_n_o <= ~({sock_cfg[1].card_rst,
				sock_cfg[0].card_rst} // RQ8
				| {2{host_rst}}); // RQ9
			pci_int_n_o <= ~pci_int_d;
			legacy_irq_o <= {card_irq[1] && sock_cfg[1].irq_legacy,
				card_irq[0] && sock_cfg[0].irq_legacy}; // RQ7
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			serr_n_o <= 1'b1;
			target_abort_o <= 1'b0;
			card_parity_error_n_o <= 2'b11;
		end
		else
		begin
			serr_n_o <= ~serr_d;
			target_abort_o <= ma_any && mabt_q; // RQ11
			card_parity_error_n_o <= ~perr_d;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			write_post_en_o <= 2'b00;
			win1_prefetchable_o <= 2'b11;
			win0_prefetchable_o <= 2'b11;
		end
		else
		begin
			write_post_en_o <= {sock_cfg[1].post_en,
				sock_cfg[0].post_en}; // RQ5
			win1_prefetchable_o <= {sock_cfg[1].win1_prefetchable,
				sock_cfg[0].win1_prefetchable}; // RQ6
			win0_prefetchable_o <= {sock_cfg[1].win0_prefetchable,
				sock_cfg[0].win0_prefetchable}; // RQ6
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			fwd_ack_o <= 1'b0;
			fwd_pass_o <= 1'b0;
			fwd_vga_o <= 1'b0;
		end
		else
		begin
			fwd_ack_o <= fwd_i.valid;
			fwd_pass_o <= fwd_i.valid && !fwd_block;
			fwd_vga_o <= fwd_i.valid && fwd_vga_d;
		end
	end

endmodule : cbr_top

`default_nettype wire

// ---- cbr_top_sva.sv ----
// port assertions of the card bridge control block
// assumes the ports of cbr_top; bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none

module cbr_top_sva (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire cbr_pkg::cbr_cfg_req_t cfg_i,
	input wire logic cfg_ack_o,
	input wire logic [31:0] cfg_rdata_o,
	input wire logic serr_en_i,
	input wire logic host_reset_in_n_i,
	input wire logic [1:0] master_abort_i,
	input wire logic [1:0] parity_err_i,
	input wire cbr_pkg::cbr_fwd_req_t fwd_i,
	input wire logic [1:0] card_reset_out_n_o,
	input wire logic [1:0] card_parity_error_n_o,
	input wire logic serr_n_o,
	input wire logic target_abort_o,
	input wire logic fwd_ack_o,
	input wire logic fwd_pass_o,
	input wire logic fwd_vga_o
);
	// ========
	// address classes
	wire logic [31:0] a = fwd_i.addr;
	wire logic isa_miss = !fwd_i.is_io || a[31:16] != 16'h0000 ||
		a[9:8] == 2'h0;
	wire logic vga_hit = fwd_i.is_io ?
		a inside {[32'h000003B0:32'h000003BB], [32'h000003C0:32'h000003DF]} :
		a inside {[32'h000A0000:32'h000BFFFF]};

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (srst_i);

	// ========
	// properties
	a_ack_follows: assert property (
		cfg_i.req && !cfg_ack_o |=> cfg_ack_o) else $error("no config answer");
	a_ack_caused: assert property (
		cfg_ack_o |-> $past(cfg_i.req) && !$past(cfg_ack_o))
		else $error("config answer without request");
	a_rdata_holds: assert property (
		!cfg_ack_o |-> $stable(cfg_rdata_o)) else $error("read data moved");
	a_reserved_zero: assert property (
		cfg_ack_o |-> cfg_rdata_o[31:27] == 5'h00 && !cfg_rdata_o[20])
		else $error("reserved control bits not zero");
	a_host_card_reset_out: assert property (
		!host_reset_in_n_i [*6] |-> card_reset_out_n_o == 2'h0)
		else $error("card reset not asserted in host reset");
	a_abort_cause: assert property (
		target_abort_o |-> $past(master_abort_i) != 2'h0)
		else $error("target abort without master abort");
	a_serr_gate: assert property (
		!serr_n_o |-> $past(serr_en_i)) else $error("system error not enabled");
	a_parity_cause: assert property (
		(~card_parity_error_n_o & ~$past(parity_err_i)) == 2'h0)
		else $error("parity error pin without error");
	a_fwd_answer: assert property (
		fwd_i.valid |=> fwd_ack_o) else $error("no forwarding answer");
	a_isa_pass: assert property (
		fwd_i.valid && isa_miss |=> fwd_pass_o) else $error("cycle blocked");
	a_vga_cause: assert property (
		fwd_vga_o |-> fwd_ack_o && $past(vga_hit))
		else $error("vga hit outside vga range");

endmodule : cbr_top_sva

bind cbr_top cbr_top_sva i_cbr_top_sva (
	.sys_clk_i, .srst_i, .cfg_i, .cfg_ack_o, .cfg_rdata_o, .serr_en_i,
	.host_reset_in_n_i, .master_abort_i, .parity_err_i, .fwd_i,
	.card_reset_out_n_o, .card_parity_error_n_o, .serr_n_o,
	.target_abort_o, .fwd_ack_o, .fwd_pass_o, .fwd_vga_o
);
`default_nettype wire

// ---- cbr_card_model.sv ----
// behavioural cards of both sockets: system errors and interrupts
// assumes request strobes from the bench beside sys_clk_i
`timescale 1ns/1ps
`default_nettype none

module cbr_card_model (
	input wire logic sys_clk_i,
	input wire logic [1:0] card_reset_out_n_i,
	input wire logic [1:0] serr_req_i,
	input wire logic [1:0] irq_req_i,
	output logic [1:0] card_system_error_n_o,
	output logic [1:0] card_irq_n_o
);
	// ========
	// a card held in reset starts no new error and raises no interrupt
	logic [2:0] left_q [2] = '{3'h0, 3'h0};

	always @(posedge sys_clk_i)
	begin
		for (int s = 0; s < 2; s++)
		begin
			if (serr_req_i[s] && card_reset_out_n_i[s])
				left_q[s] <= 3'h6;
			else if (left_q[s] != 3'h0)
				left_q[s] <= left_q[s] - 3'h1;
		end
	end

	// error held six cycles so the pin filter keeps it
	assign card_system_error_n_o[0] = left_q[0] == 3'h0;
	assign card_system_error_n_o[1] = left_q[1] == 3'h0;
	assign card_irq_n_o = ~(irq_req_i & card_reset_out_n_i);

endmodule : cbr_card_model
`default_nettype wire

// ---- cbr_top_bench.sv ----
// self-checking bench of the card bridge control block
// assumes cbr_top, cbr_card_model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "cbr_defines.svh"

module cbr_top_bench;
	logic sys_clk_i = 1'b0;
	logic srst_i = 1'b1;
	cbr_pkg::cbr_cfg_req_t cfg_i = '0;
	cbr_pkg::cbr_fwd_req_t fwd_i = '0;
	logic int_ab_tie_i = 1'b0;
	logic int_abc_tie_i = 1'b0;
	logic pme_en_i = 1'b0;
	logic ohci_irq_i = 1'b0;
	logic serr_en_i = 1'b1;
	logic host_reset_in_n_i = 1'b1;
	logic [1:0] master_abort_i = 2'h0;
	logic [1:0] parity_err_i = 2'h0;
	logic [1:0] serr_req = 2'h0;
	logic [1:0] irq_req = 2'h0;
	logic cfg_ack_o, serr_n_o, target_abort_o, fwd_ack_o, fwd_pass_o, fwd_vga_o;
	logic [31:0] cfg_rdata_o, rd_q;
	logic [2:0] pci_int_n_o;
	logic [1:0] card_reset_out_n_o, card_parity_error_n_o, legacy_irq_o;
	logic [1:0] write_post_en_o, win1_prefetchable_o, win0_prefetchable_o;
	logic [1:0] card_system_error_n_i, card_irq_n_i;
	int n_mismatch = 0;
	int checks_done = 0;

	always #12.5 sys_clk_i = ~sys_clk_i;

	cbr_top i_cbr_top (.sys_clk_i, .srst_i, .cfg_i, .cfg_ack_o, .cfg_rdata_o,
		.int_ab_tie_i, .int_abc_tie_i, .pme_en_i, .serr_en_i,
		.host_reset_in_n_i, .card_system_error_n_i, .card_irq_n_i,
		.ohci_irq_i, .master_abort_i, .parity_err_i, .fwd_i,
		.card_reset_out_n_o, .card_parity_error_n_o, .serr_n_o,
		.target_abort_o, .pci_int_n_o, .legacy_irq_o, .write_post_en_o,
		.win1_prefetchable_o, .win0_prefetchable_o, .fwd_ack_o, .fwd_pass_o,
		.fwd_vga_o);

	cbr_card_model i_cbr_card_model (.sys_clk_i,
		.card_reset_out_n_i(card_reset_out_n_o), .serr_req_i(serr_req),
		.irq_req_i(irq_req), .card_system_error_n_o(card_system_error_n_i),
		.card_irq_n_o(card_irq_n_i));

	// ========
	// access and compare tasks
	task automatic tick();
		@(posedge sys_clk_i);
		#1;
	endtask : tick

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: read %h not %h", $time, got, exp);
		end
	endtask : chk_word

	task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: pins %b not %b", $time, got, exp);
		end
	endtask : chk_pin

	// request held over the answer edge, which the block ignores
	task automatic cfg_op(input logic we, input logic [1:0] f,
		input logic [7:0] ad, input logic [3:0] be, input logic [31:0] wd);
		tick();
		cfg_i = '{req: 1'b1, we: we, func: f, addr: ad, be: be, wdata: wd};
		for (int i = 0; i < 8 && cfg_ack_o !== 1'b1; i++)
			tick();
		chk_pin({3'h0, cfg_ack_o}, 4'h1);
		rd_q = cfg_rdata_o;
		tick();
		cfg_i.req = 1'b0;
	endtask : cfg_op

	task automatic wr(input logic [1:0] f, input logic [3:0] be,
		input logic [31:0] wd);
		cfg_op(1'b1, f, `CBR_CFG_DW_OFF, be, wd);
	endtask : wr

	task automatic rd_chk(input logic [1:0] f, input logic [31:0] exp,
		input logic [31:0] mask);
		cfg_op(1'b0, f, `CBR_CFG_DW_OFF, 4'hF, 32'h00000000);
		chk_word(rd_q & mask, exp);
	endtask : rd_chk

	task automatic ev(input logic [1:0] ma, input logic [1:0] pe,
		input logic [3:0] exp);
		tick();
		master_abort_i = ma;
		parity_err_i = pe;
		tick();
		master_abort_i = 2'h0;
		parity_err_i = 2'h0;
		chk_pin({serr_n_o, target_abort_o, card_parity_error_n_o}, exp);
	endtask : ev

	task automatic fwd_chk(input logic io, input logic s,
		input logic [31:0] ad, input logic [1:0] exp);
		tick();
		fwd_i = '{valid: 1'b1, is_io: io, sock: s, addr: ad};
		tick();
		fwd_i.valid = 1'b0;
		chk_pin({1'b0, fwd_ack_o, fwd_pass_o, fwd_vga_o}, {2'h1, exp});
	endtask : fwd_chk

	task automatic host_rst(input logic pme, input logic [31:0] exp);
		pme_en_i = pme;
		host_reset_in_n_i = 1'b0;
		repeat (8) tick();
		chk_pin({2'h0, card_reset_out_n_o}, 4'h0);
		host_reset_in_n_i = 1'b1;
		repeat (6) tick();
		rd_chk(2'h0, exp, 32'hFFFF0000);
	endtask : host_rst

	task automatic stop_test();
		$display("checks %0d, mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test

	// ========
	// test sequence
	initial
	begin
		logic [7:0] pin;
		repeat (6) @(posedge sys_clk_i);
		#1;
		srst_i = 1'b0;
		chk_pin({card_reset_out_n_o, win1_prefetchable_o}, 4'h3);
		for (int t = 0; t < 4; t++)
		begin
			{int_abc_tie_i, int_ab_tie_i} = t[1:0];
			for (int f = 0; f < 3; f++)
			begin
				pin = (f == 0 || t != 0 && f == 1 || t >= 2) ? `CBR_PIN_INTA :
					(f == 1 ? `CBR_PIN_INTB : `CBR_PIN_INTC);
				rd_chk(f[1:0], {16'h0000, pin, 8'h00}, 32'h0000FF00);
			end
		end
		{int_abc_tie_i, int_ab_tie_i} = 2'h0;
		rd_chk(2'h1, 32'h03400200, 32'hFFFFFFFF);
		cfg_op(1'b0, 2'h0, 8'h40, 4'hF, 32'h00000000);
		chk_word(rd_q, 32'h00000000);
		wr(2'h0, 4'hC, 32'hFFFF0000);
		wr(2'h0, 4'h2, 32'hFFFFFFFF);
		wr(2'h3, 4'hC, 32'h00000000);
		rd_chk(2'h0, 32'h07EF0100, 32'hFFFFFFFF);
		rd_chk(2'h1, 32'h03600200, 32'hFFFFFFFF);
		chk_pin({card_reset_out_n_o, write_post_en_o}, 4'h1);
		wr(2'h0, 4'h4, 32'h00230000);
		rd_chk(2'h0, 32'h07230100, 32'hFFFFFFFF);
		chk_pin({card_reset_out_n_o, win0_prefetchable_o}, 4'h7);
		wr(2'h0, 4'h8, 32'h04000000);
		chk_pin({win1_prefetchable_o, win0_prefetchable_o}, 4'hA);
		ev(2'h0, 2'h1, 4'hA);
		ev(2'h0, 2'h2, 4'hB);
		ev(2'h2, 2'h0, 4'h7);
		serr_en_i = 1'b0;
		ev(2'h1, 2'h0, 4'hF);
		serr_en_i = 1'b1;
		wr(2'h0, 4'h4, 32'h00030000);
		ev(2'h1, 2'h0, 4'hB);
		tick();
		serr_req = 2'h1;
		tick();
		serr_req = 2'h0;
		for (int i = 0; i < 12 && serr_n_o !== 1'b0; i++)
			tick();
		chk_pin({3'h0, serr_n_o}, 4'h0);
		wr(2'h0, 4'h4, 32'h000C0000);
		fwd_chk(1'b1, 1'b0, 32'h00000100, 2'h0);
		fwd_chk(1'b1, 1'b0, 32'h000004FF, 2'h2);
		fwd_chk(1'b1, 1'b0, 32'h00010100, 2'h2);
		fwd_chk(1'b0, 1'b0, 32'h000A0000, 2'h3);
		fwd_chk(1'b1, 1'b1, 32'h00000100, 2'h2);
		fwd_chk(1'b0, 1'b1, 32'h000BFFFF, 2'h2);
		irq_req = 2'h1;
		repeat (6) tick();
		chk_pin({1'b0, pci_int_n_o}, 4'h6);
		wr(2'h0, 4'h4, 32'h008C0000);
		repeat (6) tick();
		chk_pin({pci_int_n_o, legacy_irq_o[0]}, 4'hF);
		irq_req = 2'h0;
		wr(2'h1, 4'h4, 32'h00000000);
		irq_req = 2'h2;
		ohci_irq_i = 1'b1;
		repeat (6) tick();
		chk_pin({1'b0, pci_int_n_o}, 4'h1);
		int_abc_tie_i = 1'b1;
		tick();
		chk_pin({1'b0, pci_int_n_o}, 4'h6);
		{int_abc_tie_i, int_ab_tie_i} = 2'h1;
		tick();
		chk_pin({1'b0, pci_int_n_o}, 4'h2);
		{int_abc_tie_i, int_ab_tie_i} = 2'h0;
		irq_req = 2'h0;
		ohci_irq_i = 1'b0;
		host_rst(1'b1, 32'h03000000);
		host_rst(1'b0, 32'h03400000);
		stop_test();
	end

	initial
	begin
		#100us;
		n_mismatch++;
		$display("wrong value at %0t: run did not finish", $time);
		stop_test();
	end

endmodule : cbr_top_bench
`default_nettype wire
